/* rtl/banked_data_memory_addressing.sv */
// Purpose: data address generation, bank pointer and general RAM of the core
// Assumes: one instruction cycle is four clocks; requests are taken in phase one
// Notes:   special function registers other than the bank pointer live outside
module banked_data_memory_addressing
  import banked_data_memory_addressing_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  // instruction from the execute stage
  input  wire logic                 instr_valid_i,
  input  wire logic [1:0]           op_kind_i,
  input  wire logic                 access_sel_i,
  input  wire logic [`OFFS_W-1:0]   operand_i,
  input  wire logic [`ADDR_W-1:0]   src_addr_i,
  input  wire logic [`ADDR_W-1:0]   dst_addr_i,
  input  wire logic [`DATA_W-1:0]   literal_i,
  input  wire logic                 wr_en_i,
  input  wire logic                 status_req_i,
  input  wire logic [`DATA_W-1:0]   wr_data_i,
  input  wire logic                 extended_set_enable_i,
  // results to the execute stage
  output logic [1:0]                phase_o,
  output logic [`ADDR_W-1:0]        data_addr_o,
  output logic [`DATA_W-1:0]        rd_data_o,
  output logic                      rd_valid_o,
  output logic                      status_upd_o,
  output logic [`DATA_W-1:0]        bank_pointer_o,
  output logic                      ext_map_unsupported_o,
  // special function register array
  output logic [`ADDR_W-1:0]        sfr_addr_o,
  output logic                      sfr_rd_o,
  output logic                      sfr_wr_o,
  output logic [`DATA_W-1:0]        sfr_wdata_o,
  input  wire logic [`DATA_W-1:0]   sfr_rdata_i,
  output logic                      pc_low_wr_o
);

  core_s               st_ff;
  core_s               nxt_st;
  logic [`DATA_W-1:0]  gpr_mem [`GPR_DEPTH];
  logic                gpr_we;
  logic                legal_op;

  function automatic logic in_gpr(input logic [`ADDR_W-1:0] a);
    in_gpr = (a[`ADDR_W-1:`OFFS_W] < `GPR_BANKS);
  endfunction

  function automatic logic in_sfr(input logic [`ADDR_W-1:0] a);
    in_sfr = (a >= `SFR_BASE) && (a != `BANK_PTR_ADDR);
  endfunction

  function automatic logic [`ADDR_W-1:0] direct_addr(
    input logic                a_sel,
    input logic [`BANK_W-1:0]  bank,
    input logic [`OFFS_W-1:0]  offs
  );
    if (a_sel) begin
      direct_addr = {bank, offs};
    end else if (offs < `ACCESS_SPLIT) begin
      direct_addr = {`ACCESS_LO_BANK, offs};
    end else begin
      direct_addr = {`ACCESS_HI_BANK, offs};
    end
  endfunction

  assign legal_op = (op_kind_i != 2'h3);

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.phase      = phase_e'(st_ff.phase + 2'h1);
    nxt_st.rd_valid   = 1'b0;
    nxt_st.sfr_rd     = 1'b0;
    nxt_st.sfr_wr     = 1'b0;
    nxt_st.pcl_wr     = 1'b0;
    nxt_st.status_upd = 1'b0;
    nxt_st.ext        = extended_set_enable_i;
    unique case (st_ff.phase)
      PH_ONE: begin
        nxt_st.busy = instr_valid_i && legal_op;
        if (instr_valid_i && legal_op) begin
          nxt_st.kind  = op_kind_e'(op_kind_i);
          nxt_st.wr    = (op_kind_i != OP_FILE) || wr_en_i;
          nxt_st.upd   = status_req_i && (op_kind_i == OP_FILE);
          nxt_st.dst   = dst_addr_i;
          nxt_st.wdata = literal_i;
          if (op_kind_i == OP_MOVE) begin
            nxt_st.addr = src_addr_i;
          end else if (op_kind_i == OP_FILE) begin
            nxt_st.addr = direct_addr(access_sel_i, st_ff.bank, operand_i);
          end
          nxt_st.sfr_rd = (op_kind_i != OP_LIT) && in_sfr(nxt_st.addr);
        end
      end
      PH_TWO: begin
        // operand read
        if (st_ff.busy && st_ff.kind != OP_LIT) begin
          nxt_st.rd_valid = 1'b1;
          if (st_ff.addr == `BANK_PTR_ADDR) begin
            nxt_st.rd_data = {`BANK_PTR_UNUSED, st_ff.bank};
          end else if (in_gpr(st_ff.addr)) begin
            nxt_st.rd_data = gpr_mem[st_ff.addr[`GPR_IDX_W-1:0]];
          end else if (in_sfr(st_ff.addr)) begin
            nxt_st.rd_data = sfr_rdata_i;
          end else begin
            nxt_st.rd_data = '0;
          end
          if (st_ff.kind == OP_MOVE) begin
            nxt_st.addr = st_ff.dst;
          end
        end
      end
      PH_THREE: begin
        if (st_ff.busy) begin
          nxt_st.status_upd = st_ff.upd;
          if (st_ff.wr && st_ff.kind != OP_LIT) begin
            nxt_st.wdata  = (st_ff.kind == OP_MOVE) ? st_ff.rd_data : wr_data_i;
            nxt_st.sfr_wr = in_sfr(st_ff.addr);
            nxt_st.pcl_wr = (st_ff.addr == `PCL_ADDR);
          end
        end
      end
      PH_FOUR: begin
        // destination write
        if (st_ff.busy && st_ff.wr) begin
          if (st_ff.kind == OP_LIT) begin
            nxt_st.bank = st_ff.wdata[`BANK_W-1:0];
          end else if (st_ff.addr == `BANK_PTR_ADDR) begin
            nxt_st.bank = st_ff.wdata[`BANK_W-1:0];
          end
        end
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff      <= '0;
      st_ff.bank <= `BANK_PTR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // general RAM is never reset; unimplemented banks drop the write
  assign gpr_we = !srst_i && st_ff.phase == PH_FOUR && st_ff.busy && st_ff.wr
                  && st_ff.kind != OP_LIT && in_gpr(st_ff.addr);

  always_ff @(posedge clk_i) begin
    if (gpr_we) begin
      gpr_mem[st_ff.addr[`GPR_IDX_W-1:0]] <= st_ff.wdata;
    end
  end

  assign phase_o               = st_ff.phase;
  assign data_addr_o           = st_ff.addr;
  assign rd_data_o             = st_ff.rd_data;
  assign rd_valid_o            = st_ff.rd_valid;
  assign status_upd_o          = st_ff.status_upd;
  assign bank_pointer_o        = {`BANK_PTR_UNUSED, st_ff.bank};
  assign ext_map_unsupported_o = st_ff.ext;
  assign sfr_addr_o            = st_ff.addr;
  assign sfr_rd_o              = st_ff.sfr_rd;
  assign sfr_wr_o              = st_ff.sfr_wr;
  assign sfr_wdata_o           = st_ff.wdata;
  assign pc_low_wr_o           = st_ff.pcl_wr;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_bank_upper_zero: assert property (bank_pointer_o[7:4] == 4'h0)
    else $error("bank pointer upper bits not zero");

  a_banked_addr_form: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_FILE && access_sel_i
    |=> data_addr_o == {$past(bank_pointer_o[3:0]), $past(operand_i)})
    else $error("banked address not bank plus operand");

  a_access_low_map: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_FILE && !access_sel_i
    && operand_i < 8'h60 |=> data_addr_o == {4'h0, $past(operand_i)})
    else $error("access map low half wrong");

  a_access_high_map: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_FILE && !access_sel_i
    && operand_i >= 8'h60 |=> data_addr_o == {4'hF, $past(operand_i)})
    else $error("access map high half wrong");

  a_move_full_addr: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_MOVE
    |=> data_addr_o == $past(src_addr_i) ##1 data_addr_o == $past(dst_addr_i, 2))
    else $error("move addresses wrong");

  a_unimpl_read_zero: assert property (
    phase_o == PH_TWO && rd_valid_o == 1'b0 && st_ff.busy && st_ff.kind == OP_FILE
    && !in_gpr(data_addr_o) && data_addr_o < 12'hF40 |=> rd_data_o == 8'h00)
    else $error("unimplemented read not zero");

  a_literal_load_bank: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_LIT
    |-> ##4 bank_pointer_o == {4'h0, $past(literal_i[3:0], 4)})
    else $error("literal not loaded into bank pointer");

  a_status_any_bank: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_FILE && status_req_i
    |-> ##3 status_upd_o && phase_o == PH_FOUR)
    else $error("status update missing");

  a_pcl_write_hit: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_FILE && access_sel_i
    && wr_en_i && bank_pointer_o == 8'h0F && operand_i == 8'hF9
    |-> ##3 pc_low_wr_o && sfr_wr_o)
    else $error("program counter low byte not written");

  a_single_cycle_read: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_FILE
    |-> ##2 rd_valid_o ##2 phase_o == PH_ONE)
    else $error("operand not read within one instruction cycle");

  // quarter phases run in a fixed ring of four
  a_phase_ring: assert property (
    phase_o == PH_FOUR |=> phase_o == PH_ONE)
    else $error("phase did not wrap to phase one");

  a_phase_step: assert property (
    phase_o == PH_ONE |=> phase_o == PH_TWO)
    else $error("phase did not advance to phase two");

  // pulses appear only in their own quarter phase
  a_rd_valid_phase: assert property (
    rd_valid_o |-> phase_o == PH_THREE)
    else $error("read valid outside its phase");

  a_rd_valid_pulse: assert property (
    rd_valid_o |=> !rd_valid_o)
    else $error("read valid longer than one cycle");

  a_idle_no_read: assert property (
    phase_o == PH_ONE && !instr_valid_i |-> ##2 !rd_valid_o)
    else $error("read valid without a request");

  a_status_phase: assert property (
    status_upd_o |-> phase_o == PH_FOUR)
    else $error("status update outside its phase");

  a_status_pulse: assert property (
    status_upd_o |=> !status_upd_o)
    else $error("status update longer than one cycle");

  a_sfr_rd_range: assert property (
    sfr_rd_o |-> phase_o == PH_TWO && sfr_addr_o >= 12'hF40 && sfr_addr_o != 12'hFE0)
    else $error("register read strobe outside register area");

  a_sfr_wr_range: assert property (
    sfr_wr_o |-> phase_o == PH_FOUR && sfr_addr_o >= 12'hF40 && sfr_addr_o != 12'hFE0)
    else $error("register write strobe outside register area");

  a_pcl_addr_only: assert property (
    pc_low_wr_o |-> sfr_addr_o == 12'hFF9 && sfr_wr_o)
    else $error("program counter low strobe at wrong address");

  // general RAM is written only inside the built banks
  a_ram_write_built: assert property (
    gpr_we |-> data_addr_o[11:8] < 4'h4)
    else $error("write reached an unbuilt bank");

  a_bank_moves_late: assert property (
    phase_o != PH_ONE |-> $stable(bank_pointer_o))
    else $error("bank pointer changed inside an instruction cycle");

  a_literal_no_read: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_LIT
    |-> ##2 !rd_valid_o)
    else $error("literal load read the data memory");

  a_addr_held: assert property (
    phase_o == PH_FOUR |-> $stable(data_addr_o))
    else $error("address moved between read and write");

  a_file_wdata: assert property (
    phase_o == PH_THREE && st_ff.busy && st_ff.kind == OP_FILE && st_ff.wr
    |=> sfr_wdata_o == $past(wr_data_i))
    else $error("file write data not taken");

  a_move_copies: assert property (
    phase_o == PH_THREE && st_ff.busy && st_ff.kind == OP_MOVE
    |=> sfr_wdata_o == $past(rd_data_o))
    else $error("move did not copy the source byte");

  a_bank_by_file: assert property (
    phase_o == PH_ONE && instr_valid_i && op_kind_i == OP_FILE && !access_sel_i
    && operand_i == 8'hE0 && wr_en_i
    |-> ##4 bank_pointer_o == {4'h0, $past(wr_data_i[3:0], 2)})
    else $error("bank pointer not loaded by file write");

  a_ext_flag_copy: assert property (
    !$past(srst_i) |-> ext_map_unsupported_o == $past(extended_set_enable_i))
    else $error("extended set flag not forwarded");

endmodule // banked_data_memory_addressing

/* rtl/banked_data_memory_addressing_consts.svh */
// Purpose: constants of the banked data memory address generator
// Assumes: included by the package; the design module uses its macros through it
// Notes:   all widths, offsets and reset values live here
//
// How it works
// - data memory uses a 12-bit byte address, 4096 bytes at most
// - sixteen 256-byte banks; only four general-purpose banks are built
// - reading any unimplemented location returns zero
// - banked address is bank pointer on top, operand byte below
// - only bank pointer bits 3..0 exist; upper bits read zero, ignore writes
// - load-bank-literal op writes its literal straight into the bank pointer
// - writes to unimplemented banks are dropped, reads return zero
// - status flags update even when the bank is unimplemented
// - full-address move uses both 12-bit addresses, ignores bank pointer
// - all other ops except load-bank-literal give 8-bit operand, resolved by bank or access map
// - access map: 00h-5Fh to bank 0, 60h-FFh to top of bank 15
// - access-select bit 1 uses bank pointer plus operand
// - access-select bit 0 uses the access map, bank pointer ignored
// - access-map op completes in one instruction cycle; a write to E0h (bank pointer at FE0h) updates the bank
// - bank 0Fh with offset F9h writes the program counter low byte
// - only the access map for extended set disabled is implemented
// - operand read in phase two, destination write in phase four
// - special function registers occupy F40h to FFFh
// - general RAM starts at 000h, never cleared by any reset
`ifndef BANKED_DATA_MEMORY_ADDRESSING_CONSTS_SVH
`define BANKED_DATA_MEMORY_ADDRESSING_CONSTS_SVH

`define ADDR_W          12
`define DATA_W          8
`define BANK_W          4
`define OFFS_W          8
`define GPR_IDX_W       10
`define GPR_BANKS       4'h4
`define GPR_DEPTH       1024
`define ACCESS_SPLIT    8'h60
`define ACCESS_LO_BANK  4'h0
`define ACCESS_HI_BANK  4'hF
`define SFR_BASE        12'hF40
`define BANK_PTR_ADDR   12'hFE0
`define PCL_ADDR        12'hFF9
`define BANK_PTR_RST    4'h0
`define BANK_PTR_UNUSED 4'h0

`endif

/* rtl/banked_data_memory_addressing_pkg.sv */
// Purpose: types of the banked data memory address generator
// Assumes: constants header on the include path
// Notes:   one state struct holds every register of the block except the general RAM array
package banked_data_memory_addressing_pkg;
`include "banked_data_memory_addressing_consts.svh"

  typedef enum logic [1:0] {
    PH_ONE   = 2'h0,
    PH_TWO   = 2'h1,
    PH_THREE = 2'h2,
    PH_FOUR  = 2'h3
  } phase_e;

  typedef enum logic [1:0] {
    OP_FILE = 2'h0,
    OP_LIT  = 2'h1,
    OP_MOVE = 2'h2
  } op_kind_e;

  typedef struct packed {
    phase_e               phase;
    logic                 busy;
    op_kind_e             kind;
    logic                 wr;
    logic                 upd;
    logic [`ADDR_W-1:0]   dst;
    logic [`ADDR_W-1:0]   addr;
    logic [`BANK_W-1:0]   bank;
    logic [`DATA_W-1:0]   rd_data;
    logic                 rd_valid;
    logic [`DATA_W-1:0]   wdata;
    logic                 sfr_rd;
    logic                 sfr_wr;
    logic                 pcl_wr;
    logic                 status_upd;
    logic                 ext;
  } core_s;
endpackage

/* tb/banked_data_memory_addressing_bench.sv */
// Purpose: self-checking bench of the banked data memory address block
// Assumes: one request per four-clock instruction cycle, taken in phase one
// Notes:   the special function register array is a behavioural model
module banked_data_memory_addressing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, srst_i, instr_valid_i, access_sel_i, wr_en_i, status_req_i;
  logic        extended_set_enable_i, rd_valid_o, status_upd_o, ext_map_unsupported_o;
  logic        sfr_rd_o, sfr_wr_o, pc_low_wr_o, rv, su, sr, sw, pw;
  logic [1:0]  op_kind_i, phase_o;
  logic [7:0]  operand_i, literal_i, wr_data_i, rd_data_o, bank_pointer_o;
  logic [7:0]  sfr_wdata_o, sfr_rdata_i, rdd, swd;
  logic [11:0] src_addr_i, dst_addr_i, data_addr_o, sfr_addr_o, a1, a2, sad;
  int          failures, checks, cycles;

  banked_data_memory_addressing dut_u (.*);
  sfr_array_model sfr_u (.clk_i(clk_i), .sfr_addr_i(sfr_addr_o), .sfr_rd_i(sfr_rd_o),
    .sfr_wr_i(sfr_wr_o), .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one instruction cycle; results of each phase are captured
  task automatic op(input logic [1:0] k, input logic a, input logic [7:0] opr, lit, wd,
                    input logic [11:0] src, dst, input logic wr);
    while (phase_o !== 2'h0) begin
      @(posedge clk_i);
      #1;
    end
    {instr_valid_i, op_kind_i, access_sel_i, operand_i, literal_i} = {1'b1, k, a, opr, lit};
    {src_addr_i, dst_addr_i, wr_en_i, status_req_i} = {src, dst, wr, wr};
    @(posedge clk_i);
    #1;
    instr_valid_i = 1'b0;
    a1 = data_addr_o;
    sr = sfr_rd_o;
    chk({10'h0, phase_o}, 12'h001);
    @(posedge clk_i);
    #1;
    wr_data_i = wd;
    {a2, rv, rdd} = {data_addr_o, rd_valid_o, rd_data_o};
    @(posedge clk_i);
    #1;
    {su, sw, pw, swd} = {status_upd_o, sfr_wr_o, pc_low_wr_o, sfr_wdata_o};
    sad = sfr_addr_o;
    @(posedge clk_i);
    #1;
  endtask

  task automatic fop(input logic a, input logic [7:0] opr, wd, input logic wr);
    op(2'h0, a, opr, 8'h00, wd, 12'h000, 12'h000, wr);
  endtask

  task automatic lb(input logic [7:0] lit);
    op(2'h1, 1'b0, 8'h00, lit, 8'h00, 12'h000, 12'h000, 1'b0);
  endtask

  task automatic do_reset();
    srst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    {failures, checks, cycles} = '0;
    {instr_valid_i, access_sel_i, wr_en_i, status_req_i, extended_set_enable_i} = '0;
    {op_kind_i, operand_i, literal_i, wr_data_i, src_addr_i, dst_addr_i} = '0;
    do_reset();
    chk({4'h0, bank_pointer_o}, 12'h000);
    lb(8'hF2);
    chk({4'h0, bank_pointer_o}, 12'h002);
    fop(1'b1, 8'h34, 8'hA5, 1'b1);
    chk(a1, 12'h234);
    chk({11'h0, su}, 12'h001);
    fop(1'b1, 8'h34, 8'h00, 1'b0);
    chk({3'h0, rv, rdd}, 12'h1A5);
    fop(1'b0, 8'h10, 8'h5A, 1'b1);
    chk(a1, 12'h010);
    fop(1'b0, 8'h5F, 8'h00, 1'b0);
    chk(a1, 12'h05F);
    fop(1'b0, 8'h60, 8'h00, 1'b0);
    chk(a1, 12'hF60);
    chk({3'h0, sr, rdd}, 12'h11C);
    fop(1'b0, 8'hFF, 8'h00, 1'b0);
    chk(a1, 12'hFFF);
    fop(1'b0, 8'h80, 8'h99, 1'b1);
    chk({2'h0, sw, pw, swd}, 12'h299);
    chk(sad, 12'hF80);
    fop(1'b0, 8'hE0, 8'hFC, 1'b1);
    chk({4'h0, bank_pointer_o}, 12'h00C);
    fop(1'b1, 8'h34, 8'h77, 1'b1);
    chk({a1[11:1], su}, 12'hC35);
    fop(1'b1, 8'h34, 8'h00, 1'b0);
    chk({3'h0, rv, rdd}, 12'h100);
    lb(8'h0F);
    fop(1'b1, 8'h20, 8'h00, 1'b0);
    chk({3'h0, rv, rdd}, 12'h100);
    fop(1'b1, 8'hF9, 8'h40, 1'b1);
    chk({2'h0, sw, pw, swd}, 12'h340);
    op(2'h2, 1'b1, 8'hFF, 8'h00, 8'h00, 12'h234, 12'h011, 1'b0);
    chk(a1, 12'h234);
    chk(a2, 12'h011);
    fop(1'b0, 8'h11, 8'h00, 1'b0);
    chk({3'h0, rv, rdd}, 12'h1A5);
    extended_set_enable_i = 1'b1;
    fop(1'b0, 8'h10, 8'h00, 1'b0);
    chk({3'h0, ext_map_unsupported_o, rdd}, 12'h15A);
    do_reset();
    chk({4'h0, bank_pointer_o}, 12'h000);
    fop(1'b0, 8'h80, 8'h00, 1'b0);
    chk({4'h0, rdd}, 12'h099);
    fop(1'b0, 8'h10, 8'h00, 1'b0);
    chk({4'h0, rdd}, 12'h05A);
    finish_test();
  end
endmodule // banked_data_memory_addressing_bench

/* tb/sfr_array_model.sv */
// Purpose: special function register array beside the address block
// Assumes: read answer is combinational while the read strobe is high
// Notes:   an idle read bus shows the inverse of the last answer
module sfr_array_model (
  // clock
  input  wire logic        clk_i,
  // register array port
  input  wire logic [11:0] sfr_addr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic [7:0]       sfr_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [192];
  logic [7:0] last;
  initial begin
    last = 8'h00;
    for (int i = 0; i < 192; i++) mem[i] = 8'(i) ^ 8'h3C;
  end
  // storage spans F40h..FFFh only
  assign sfr_rdata_o = sfr_rd_i ? mem[8'(sfr_addr_i - 12'hF40)] : ~last;
  always @(posedge clk_i) begin
    if (sfr_rd_i) last <= sfr_rdata_o;
    if (sfr_wr_i) mem[8'(sfr_addr_i - 12'hF40)] <= sfr_wdata_i;
  end
endmodule // sfr_array_model
